/* File: src/asbc_consts.svh */
`ifndef ASBC_CONSTS_SVH
`define ASBC_CONSTS_SVH
// Contract
// RQ1 - Reference select picks high and low references
// RQ2 - Offset calibration ties both inputs low
// RQ3 - Otherwise inputs follow channel or scan
// RQ4 - Scan enable selects scanning of inputs
// RQ5 - Fill status shows half being filled
// RQ6 - Software reads the half not filling
// RQ7 - Interrupt after every N+1 sequences
// RQ8 - Buffer mode: two halves or one
// RQ9 - Alternate: A first, then B/A alternating
// RQ10 - Alternate off: always A settings
// RQ11 - Unused bits read zero, ignore writes
// RQ12 - Reset clears every field and status
// RQ13 - Split mode swaps half on interrupt

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ASBC_OFF_CTRL      8'h00
`define ASBC_OFF_IRQ_STAT  8'h04
`define ASBC_OFF_IRQ_MASK  8'h08

// ----------------------------------------
// Control word fields
// ----------------------------------------
`define ASBC_CTRL_WMASK    32'h0000_f43f
`define ASBC_REF_LSB       13
`define ASBC_OFFSET_CALIBRATION_ENABLE_BIT    12
`define ASBC_SCAN_BIT      10
`define ASBC_FILL_BIT      7
`define ASBC_SPI_LSB       2
`define ASBC_SPLIT_BIT     1
`define ASBC_ALT_BIT       0
`define ASBC_CTRL_RESET    32'h0000_0000

// ----------------------------------------
// Reference encodings
// ----------------------------------------
`define ASBC_REF_RAILS     3'h0
`define ASBC_REF_EXT_HI    3'h1
`define ASBC_REF_EXT_LO    3'h2
`define ASBC_REF_EXT_BOTH  3'h3

// ----------------------------------------
// Interrupt status bits
// ----------------------------------------
`define ASBC_IRQ_SEQ_BIT   0
`define ASBC_IRQ_HALF_BIT  1
`define ASBC_IRQ_WIDTH     2
`endif

/* File: src/asbc_pkg.sv */
package asbc_pkg;
    typedef struct packed {
        logic [2:0] ref_sel;
        logic       offset_calibration_enable;
        logic       scan;
        logic [3:0] seq_per_irq;
        logic       split;
        logic       alt;
    } asbc_ctrl_t;

    typedef struct packed {
        logic       high_ext;
        logic       low_ext;
        logic       inputs_to_low;
        logic       use_scan;
        logic       use_mux_b;
        logic       upper_half;
    } asbc_core_t;
endpackage

/* File: src/asbc_seq_count.sv */
`timescale 1ns/100ps
`include "asbc_consts.svh"
module asbc_seq_count
    import asbc_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       done_i,
    input  wire logic [3:0] limit_i,
    output logic            hit_o
);
    typedef struct packed {
        logic [3:0] cnt;
        logic       hit;
    } asbc_cnt_t;

    asbc_cnt_t st;
    asbc_cnt_t next_st;

    // Limit change mid-count takes effect on the next compare
    always_comb begin
        next_st     = st;
        next_st.hit = 1'b0;
        if (done_i) begin
            if (st.cnt >= limit_i) begin // RQ7
                next_st.cnt = 4'h0;
                next_st.hit = 1'b1;
            end else begin
                next_st.cnt = st.cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign hit_o = st.hit;

    every_n_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ7
        done_i && limit_i == 4'h0 |=> hit_o)
        else $error("Sequence count missed interrupt");
endmodule

/* File: src/asbc_top.sv */
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`include "asbc_consts.svh"
module asbc_top
    import asbc_pkg::*;
(
    input  wire logic        CLOCK_I,
    input  wire logic        RST_N_I,
    input  wire logic [7:0]  ADDR_I,
    input  wire logic [31:0] WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [31:0] RDATA_O,
    input  wire logic        SAMPLE_START_I,
    input  wire logic        SEQ_DONE_I,
    output logic      [5:0]  CORE_O,
    output logic             IRQ_O
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        asbc_ctrl_t ctrl;
        logic       fill;
        logic       mux_b;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic [31:0] rdata;
        asbc_core_t core;
        logic       irq;
    } asbc_state_t;

    asbc_state_t st;
    asbc_state_t next_st;
    logic        seq_hit;

    function automatic logic [31:0] ctrl_word(input asbc_ctrl_t c, input logic f);
        logic [31:0] w;
        w = 32'h0;
        w[`ASBC_REF_LSB +: 3]  = c.ref_sel;
        w[`ASBC_OFFSET_CALIBRATION_ENABLE_BIT]    = c.offset_calibration_enable;
        w[`ASBC_SCAN_BIT]      = c.scan;
        w[`ASBC_FILL_BIT]      = f;
        w[`ASBC_SPI_LSB +: 4]  = c.seq_per_irq;
        w[`ASBC_SPLIT_BIT]     = c.split;
        w[`ASBC_ALT_BIT]       = c.alt;
        return w;
    endfunction

    function automatic asbc_ctrl_t ctrl_fields(input logic [31:0] w);
        asbc_ctrl_t c;
        c             = '0;
        c.ref_sel     = w[`ASBC_REF_LSB +: 3];
        c.offset_calibration_enable      = w[`ASBC_OFFSET_CALIBRATION_ENABLE_BIT];
        c.scan        = w[`ASBC_SCAN_BIT];
        c.seq_per_irq = w[`ASBC_SPI_LSB +: 4];
        c.split       = w[`ASBC_SPLIT_BIT];
        c.alt         = w[`ASBC_ALT_BIT];
        return c;
    endfunction

    // ----------------------------------------
    // Sequence counter
    // ----------------------------------------
    asbc_seq_count asbc_seq_count_inst (
        .clk_i   (CLOCK_I),
        .rst_n_i (RST_N_I),
        .done_i  (SEQ_DONE_I),
        .limit_i (st.ctrl.seq_per_irq),
        .hit_o   (seq_hit)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic [1:0] ev;
        next_st = st;
        ev      = 2'h0;
        next_st.rdata = 32'h0;

        if (WR_I && ADDR_I == `ASBC_OFF_CTRL) begin // RQ11
            next_st.ctrl = ctrl_fields(WDATA_I);
        end
        if (WR_I && ADDR_I == `ASBC_OFF_IRQ_MASK) begin
            next_st.irq_mask = WDATA_I[1:0];
        end
        if (WR_I && ADDR_I == `ASBC_OFF_IRQ_STAT) begin
            next_st.irq_stat = st.irq_stat & ~WDATA_I[1:0];
        end

        // Half swap only meaningful with split buffer
        if (!st.ctrl.split) begin // RQ8
            next_st.fill = 1'b0;
        end else if (seq_hit) begin
            next_st.fill = ~st.fill; // RQ13
            ev[`ASBC_IRQ_HALF_BIT] = 1'b1;
        end
        if (seq_hit) begin
            ev[`ASBC_IRQ_SEQ_BIT] = 1'b1; // RQ7
        end
        // Set wins over a same-cycle clear
        next_st.irq_stat = next_st.irq_stat | ev;

        // Alternate sampling restarts at A when disabled
        if (!st.ctrl.alt) begin // RQ10
            next_st.mux_b = 1'b0;
        end else if (SAMPLE_START_I) begin
            next_st.mux_b = ~st.mux_b; // RQ9
        end

        if (RD_I) begin
            case (ADDR_I)
                `ASBC_OFF_CTRL:     next_st.rdata = ctrl_word(st.ctrl, st.fill); // RQ5
                `ASBC_OFF_IRQ_STAT: next_st.rdata = {30'h0, st.irq_stat};
                `ASBC_OFF_IRQ_MASK: next_st.rdata = {30'h0, st.irq_mask};
                default:            next_st.rdata = 32'h0;
            endcase
        end

        case (st.ctrl.ref_sel) // RQ1
            `ASBC_REF_EXT_HI: begin
                next_st.core.high_ext = 1'b1;
                next_st.core.low_ext  = 1'b0;
            end
            `ASBC_REF_EXT_LO: begin
                next_st.core.high_ext = 1'b0;
                next_st.core.low_ext  = 1'b1;
            end
            `ASBC_REF_EXT_BOTH: begin
                next_st.core.high_ext = 1'b1;
                next_st.core.low_ext  = 1'b1;
            end
            default: begin
                next_st.core.high_ext = 1'b0;
                next_st.core.low_ext  = 1'b0;
            end
        endcase
        next_st.core.inputs_to_low = st.ctrl.offset_calibration_enable;                 // RQ2
        next_st.core.use_scan      = st.ctrl.scan && !st.ctrl.offset_calibration_enable; // RQ3 RQ4
        next_st.core.use_mux_b     = st.mux_b;
        // No extra lag, so the half flag never trails the fill status
        next_st.core.upper_half    = next_st.fill;
        next_st.irq = |(next_st.irq_stat & st.irq_mask);
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            st <= '0; // RQ12
        end else begin
            st <= next_st;
        end
    end

    assign RDATA_O = st.rdata;
    assign CORE_O  = st.core;
    assign IRQ_O   = st.irq;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    fill_swap_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ13
        st.ctrl.split && seq_hit |=> st.fill != $past(st.fill))
        else $error("Fill half did not swap");
    fill_zero_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ5
        !st.ctrl.split |=> !st.fill)
        else $error("Fill status set outside split mode");
    unused_zero_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ11
        RD_I && ADDR_I == `ASBC_OFF_CTRL |=> (RDATA_O & ~`ASBC_CTRL_WMASK & ~32'h80) == 32'h0)
        else $error("Unused control bits not zero");
    fill_read_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ5
        RD_I && ADDR_I == `ASBC_OFF_CTRL |=> RDATA_O[`ASBC_FILL_BIT] == $past(st.fill))
        else $error("Fill status misread");
    offset_calibration_enable_low_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ2
        st.ctrl.offset_calibration_enable |=> CORE_O[3] && !CORE_O[2])
        else $error("Offset calibration not applied");
    scan_sel_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ4
        st.ctrl.scan && !st.ctrl.offset_calibration_enable |=> CORE_O[2])
        else $error("Scan not selected");
    ref_rails_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ1
        st.ctrl.ref_sel[2] |=> CORE_O[5:4] == 2'h0)
        else $error("Reference not rails for 1xx");
    alt_off_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ10
        !st.ctrl.alt |=> !st.mux_b)
        else $error("B settings used without alternate");
    alt_flip_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ9
        st.ctrl.alt && SAMPLE_START_I |=> st.mux_b != $past(st.mux_b))
        else $error("Alternate sampling did not flip");
    split_mode_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ8
        !st.ctrl.split |-> !CORE_O[0] || $past(st.ctrl.split))
        else $error("Upper half used in single buffer mode");
    irq_level_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ7
        seq_hit && st.irq_mask[0] |=> IRQ_O)
        else $error("Interrupt not raised");

    // ----------------------------------------
    // Checks: references and inputs
    // ----------------------------------------
    ref_zero_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ1
        st.ctrl.ref_sel == `ASBC_REF_RAILS
        |=> CORE_O[5:4] == 2'h0)
        else $error("Rails not selected for code zero");

    ref_high_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ1
        st.ctrl.ref_sel == `ASBC_REF_EXT_HI
        |=> CORE_O[5:4] == 2'h2)
        else $error("External high reference not selected");

    ref_low_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ1
        st.ctrl.ref_sel == `ASBC_REF_EXT_LO
        |=> CORE_O[5:4] == 2'h1)
        else $error("External low reference not selected");

    ref_both_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ1
        st.ctrl.ref_sel == `ASBC_REF_EXT_BOTH
        |=> CORE_O[5:4] == 2'h3)
        else $error("Both external references not selected");

    cal_off_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ3
        !st.ctrl.offset_calibration_enable
        |=> !CORE_O[3] && CORE_O[2] == $past(st.ctrl.scan))
        else $error("Inputs not following channel or scan");

    scan_off_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ4
        !st.ctrl.scan
        |=> !CORE_O[2])
        else $error("Scan used while disabled");

    cal_scan_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ2
        st.ctrl.offset_calibration_enable && st.ctrl.scan
        |=> !CORE_O[2])
        else $error("Scan not overridden by calibration");

    // ----------------------------------------
    // Checks: alternate sampling
    // ----------------------------------------
    alt_hold_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ9
        st.ctrl.alt && !SAMPLE_START_I
        |=> $stable(st.mux_b))
        else $error("Alternation moved without a sample");

    mux_core_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ9
        st.mux_b
        |=> CORE_O[1])
        else $error("B settings not passed to core");

    mux_idle_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ10
        !st.mux_b
        |=> !CORE_O[1])
        else $error("B settings shown while A selected");

    alt_first_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ10
        !st.ctrl.alt
        |-> ##2 !CORE_O[1])
        else $error("A settings not restored");

    // ----------------------------------------
    // Checks: buffer halves
    // ----------------------------------------
    // In split mode halves only swap on an interrupt, never on a write
    half_hold_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ13
        st.ctrl.split && !seq_hit
        |=> $stable(st.fill))
        else $error("Fill half moved without interrupt");

    half_core_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ5
        1'b1
        |-> CORE_O[0] == st.fill)
        else $error("Core half differs from fill status");

    half_stat_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ13
        st.ctrl.split && seq_hit
        |=> st.irq_stat[`ASBC_IRQ_HALF_BIT])
        else $error("Half swap event not latched");

    no_half_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ8
        !st.ctrl.split && !st.irq_stat[`ASBC_IRQ_HALF_BIT]
        |=> !st.irq_stat[`ASBC_IRQ_HALF_BIT])
        else $error("Half swap event in single buffer mode");

    // ----------------------------------------
    // Checks: interrupts
    // ----------------------------------------
    seq_stat_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ7
        seq_hit
        |=> st.irq_stat[`ASBC_IRQ_SEQ_BIT])
        else $error("Sequence event not latched");

    irq_quiet_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ7
        !seq_hit && (st.irq_stat & st.irq_mask) == 2'h0
        |=> !IRQ_O)
        else $error("Interrupt without unmasked status");

    irq_hold_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ7
        !seq_hit && !WR_I && (st.irq_stat & st.irq_mask) != 2'h0
        |=> IRQ_O)
        else $error("Interrupt dropped while status pending");

    stat_hold_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ7
        !seq_hit && !WR_I
        |=> $stable(st.irq_stat))
        else $error("Status changed without event or write");

    stat_read_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ7
        RD_I && ADDR_I == `ASBC_OFF_IRQ_STAT
        |=> RDATA_O == {30'h0, $past(st.irq_stat)})
        else $error("Status read wrong");

    mask_read_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ7
        RD_I && ADDR_I == `ASBC_OFF_IRQ_MASK
        |=> RDATA_O == {30'h0, $past(st.irq_mask)})
        else $error("Mask read wrong");

    mask_write_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ7
        WR_I && ADDR_I == `ASBC_OFF_IRQ_MASK
        |=> {30'h0, st.irq_mask} == ($past(WDATA_I) & 32'h0000_0003))
        else $error("Mask write lost");

    // ----------------------------------------
    // Checks: register port
    // ----------------------------------------
    ctrl_write_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ11
        WR_I && ADDR_I == `ASBC_OFF_CTRL
        |=> st.ctrl == ctrl_fields($past(WDATA_I)))
        else $error("Control write lost");

    ctrl_hold_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ11
        !(WR_I && ADDR_I == `ASBC_OFF_CTRL)
        |=> $stable(st.ctrl))
        else $error("Control changed without write");

    rdata_idle_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ11
        !RD_I
        |=> RDATA_O == 32'h0)
        else $error("Read data not zero when idle");

    unmapped_read_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ11
        RD_I && ADDR_I != `ASBC_OFF_CTRL && ADDR_I != `ASBC_OFF_IRQ_STAT && ADDR_I != `ASBC_OFF_IRQ_MASK
        |=> RDATA_O == 32'h0)
        else $error("Unmapped read not zero");

    ctrl_read_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RQ1
        RD_I && ADDR_I == `ASBC_OFF_CTRL
        |=> RDATA_O[`ASBC_REF_LSB +: 3] == $past(st.ctrl.ref_sel))
        else $error("Reference field misread");
endmodule

/* File: tb/asbc_core_model.sv */
`timescale 1ns/100ps
module asbc_core_model (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       go_i,
    input  wire logic [3:0] gap_i,
    output logic            start_o,
    output logic            done_o,
    output logic            busy_o
);
    // --------
    // Sample then convert
    // --------
    logic [3:0] cnt;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt     <= 4'h0;
            start_o <= 1'h0;
            done_o  <= 1'h0;
        end else begin
            start_o <= go_i && cnt == 4'h0;
            done_o  <= cnt == 4'h1;
            if (go_i && cnt == 4'h0) begin
                cnt <= gap_i;
            end else if (cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end
        end
    end
    // Busy spans the last pulse so callers never race it
    assign busy_o = cnt != 4'h0 || start_o || done_o;
endmodule

/* File: tb/tb_asbc_top.sv */
`timescale 1ns/100ps
`include "asbc_consts.svh"
module tb_asbc_top;
    typedef struct packed {
        logic [31:0] w;
        logic [31:0] r;
        logic [5:0]  c;
    } asbc_row_t;
    localparam logic [7:0] ctl = `ASBC_OFF_CTRL;
    localparam logic [7:0] sta = `ASBC_OFF_IRQ_STAT;
    localparam logic [7:0] msk = `ASBC_OFF_IRQ_MASK;
    logic        clk = 1'h0;
    logic        rst_n = 1'h0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr_s = 1'h0;
    logic        rd_s = 1'h0;
    logic        go = 1'h0;
    logic [3:0]  gap = 4'h1;
    logic [31:0] rdata;
    logic [5:0]  core;
    logic        irq;
    logic        start;
    logic        done;
    logic        busy;
    int          miscompares = 0;
    int          cmp_count = 0;
    asbc_row_t   rows [10] = '{'{32'h0, 32'h0, 6'h00}, '{32'h2000, 32'h2000, 6'h20},
        '{32'h4000, 32'h4000, 6'h10}, '{32'h6000, 32'h6000, 6'h30}, '{32'h8000, 32'h8000, 6'h00},
        '{32'ha000, 32'ha000, 6'h00}, '{32'he000, 32'he000, 6'h00}, '{32'h0400, 32'h0400, 6'h04},
        '{32'h1400, 32'h1400, 6'h08}, '{32'hffff_ffff, 32'hf43f, 6'h08}};

    asbc_top asbc_top_inst (.CLOCK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .SAMPLE_START_I(start), .SEQ_DONE_I(done),
        .CORE_O(core), .IRQ_O(irq));
    asbc_core_model asbc_core_model_inst (.clk_i(clk), .rst_n_i(rst_n), .go_i(go), .gap_i(gap),
        .start_o(start), .done_o(done), .busy_o(busy));

    always #2.5 clk = ~clk;

    // --------
    // Helpers
    // --------
    task automatic finish_test;
        $display("Checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'h1;
        @(posedge clk);
        wr_s  <= 1'h0;
        @(posedge clk);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        addr <= a;
        rd_s <= 1'h1;
        @(posedge clk);
        rd_s <= 1'h0;
        #1 chk("rdata", rdata, exp);
        @(posedge clk);
    endtask
    task automatic ochk(input logic [5:0] c, input logic i);
        #1 chk("core", {26'h0, core}, {26'h0, c});
        chk("irq", {31'h0, irq}, {31'h0, i});
        @(posedge clk);
    endtask
    // Alternates prompt and slow conversions
    task automatic seq(input int n);
        repeat (n) begin
            go  <= 1'h1;
            gap <= gap ^ 4'h7;
            @(posedge clk);
            go  <= 1'h0;
            repeat (40) begin
                #1 if (busy !== 1'h1) break;
                @(posedge clk);
            end
            repeat (4) @(posedge clk);
        end
    endtask

    // --------
    // Sequence
    // --------
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        rchk(ctl, 32'h0);
        rchk(sta, 32'h0);
        rchk(msk, 32'h0);
        ochk(6'h00, 1'h0);
        foreach (rows[i]) begin
            wr(ctl, rows[i].w);
            rchk(ctl, rows[i].r);
            ochk(rows[i].c, 1'h0);
        end
        wr(8'h0c, 32'hffff_ffff);
        rchk(8'h0c, 32'h0);
        rchk(ctl, 32'hf43f);
        wr(msk, 32'h1);
        wr(ctl, 32'h000a);
        seq(2);
        ochk(6'h00, 1'h0);
        seq(1);
        ochk(6'h01, 1'h1);
        rchk(sta, 32'h3);
        rchk(ctl, 32'h008a);
        wr(sta, 32'h3);
        rchk(sta, 32'h0);
        ochk(6'h01, 1'h0);
        wr(ctl, 32'h003c);
        rchk(ctl, 32'h003c);
        seq(15);
        ochk(6'h00, 1'h0);
        seq(1);
        ochk(6'h00, 1'h1);
        rchk(sta, 32'h1);
        // Masked event still latches its status bit
        wr(sta, 32'h1);
        wr(msk, 32'h0);
        wr(ctl, 32'h0);
        seq(1);
        ochk(6'h00, 1'h0);
        rchk(sta, 32'h1);
        wr(msk, 32'h1);
        rchk(msk, 32'h1);
        ochk(6'h00, 1'h1);
        wr(sta, 32'h1);
        wr(msk, 32'h0);
        wr(ctl, 32'h1);
        for (int k = 0; k < 3; k++) begin
            ochk({4'h0, k[0], 1'h0}, 1'h0);
            seq(1);
        end
        wr(ctl, 32'h0);
        seq(1);
        ochk(6'h00, 1'h0);
        wr(ctl, 32'hf43f);
        rst_n <= 1'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        rchk(ctl, 32'h0);
        finish_test;
    end

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        finish_test;
    end
endmodule
